// [rx_status_pkg.sv]
// Shared constants and types for the contactless receive status block
package rx_status_pkg;

	// ---------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [9:0] IDX_ERROR = 10'h00a;
	localparam logic [9:0] IDX_STATUS = 10'h00b;
	localparam logic [9:0] IDX_BITCTRL = 10'h00c;
	localparam logic [9:0] IDX_FIRST_COLLISION_POSITION = 10'h00d;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int ERR_SHORT = 4;
	localparam int ERR_EMPTY = 3;
	localparam int ERR_COLL = 2;
	localparam int ERR_PROT = 1;
	localparam int ERR_INTEG = 0;
	localparam int ERR_COUNT = 5;
	localparam int ST_CIPHER = 5;
	localparam int RBC_KEEP = 7;
	localparam int RBC_OFFSET_LSB = 4;
	localparam int RBC_COLLISION_AS_INTEGRITY_ERROR = 3;
	localparam int RBC_LAST_LSB = 0;
	localparam int COLL_VALID = 7;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] BITCTRL_RESET = 8'h00;
	localparam logic CIPHER_RESET = 1'b0;
	localparam logic [4:0] ERROR_RESET = 5'h00;

	// ---------------------------------------------------------------
	// Counts
	// ---------------------------------------------------------------
	localparam logic [7:0] MIN_FRAME_BITS = 8'h04;
	localparam logic [7:0] SUPPRESS_MIN_BITS = 8'h18;
	localparam logic [8:0] COLL_POS_LIMIT = 9'h040;
	localparam int QUEUE_DEPTH = 4;

	typedef enum logic [2:0] {
		LS_IDLE = 3'b000,
		LS_TX_WAIT = 3'b001,
		LS_TXING = 3'b011,
		LS_RX_WAIT = 3'b101,
		LS_WAIT_DATA = 3'b110,
		LS_RECV = 3'b111
	} link_state_t;

	typedef enum logic [2:0] {
		CMD_IDLE = 3'b000,
		CMD_TRANSMIT = 3'b001,
		CMD_RECEIVE = 3'b010,
		CMD_TRANSCEIVE = 3'b011,
		CMD_AUTH = 3'b100
	} cmd_t;

endpackage

// [error_flag_bank.sv]
// Sticky error flags with per-bit set and clear
`timescale 1ns/1ps
`default_nettype none
module error_flag_bank
	import rx_status_pkg::*;
#(
	parameter int N = ERR_COUNT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [N-1:0] set,
	input wire logic [N-1:0] clr,
	output logic [N-1:0] flags
);

	typedef struct packed {
		logic [N-1:0] f;
	} bank_t;

	bank_t s_q;
	bank_t s_d;

	// Set beats clear so an event in the clearing cycle survives
	always_comb begin
		s_d = s_q;
		for (int i = 0; i < N; i++) begin
			if (set[i]) begin
				s_d.f[i] = 1'b1;
			end else if (clr[i]) begin
				s_d.f[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign flags = s_q.f;

endmodule
`default_nettype wire

// [rx_bit_packer.sv]
// Packs received bits into bytes with alignment and collision tracking
`timescale 1ns/1ps
`default_nettype none
module rx_bit_packer
	import rx_status_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic finish,
	input wire logic [2:0] offset,
	input wire logic keep,
	input wire logic bit_stb,
	input wire logic bit_val,
	input wire logic coll_stb,
	output logic byte_stb,
	output logic [7:0] byte_data,
	output logic [2:0] fill_pos,
	output logic [7:0] bit_count,
	output logic [6:0] coll_pos,
	output logic coll_valid
);

	typedef struct packed {
		logic [7:0] sh;
		logic [2:0] pos;
		logic [2:0] align;
		logic have;
		logic [7:0] cnt;
		logic seen;
		logic [6:0] cpos;
		logic cvalid;
		logic byte_stb;
		logic [7:0] byte_data;
	} pack_t;

	pack_t s_q;
	pack_t s_d;

	always_comb begin
		logic v;
		logic [8:0] sum;
		logic [7:0] nsh;
		v = 1'b0;
		sum = 9'(s_q.align) + 9'(s_q.cnt);
		nsh = s_q.sh;
		s_d = s_q;
		s_d.byte_stb = 1'b0;
		if (clear) begin
			s_d = '0;
			s_d.pos = offset; // [R15]
			s_d.align = offset;
		end else if (finish) begin
			if (s_q.have) begin
				s_d.byte_stb = 1'b1;
				s_d.byte_data = s_q.sh;
				s_d.sh = '0;
				s_d.have = 1'b0;
			end
		end else if (bit_stb) begin
			// Zero-fill after a collision so anticollision sees a clean UID prefix
			v = (s_q.seen && !keep) ? 1'b0 : bit_val; // [R14]
			nsh[s_q.pos] = v; // [R15]
			if (coll_stb && !s_q.seen) begin
				s_d.seen = 1'b1;
				s_d.cvalid = (sum < COLL_POS_LIMIT); // [R19]
				s_d.cpos = sum[6:0]; // [R20]
			end
			if (s_q.cnt != 8'hff) begin
				s_d.cnt = s_q.cnt + 8'h01;
			end
			if (s_q.pos == 3'd7) begin
				s_d.byte_stb = 1'b1;
				s_d.byte_data = nsh;
				s_d.sh = '0;
				s_d.have = 1'b0;
				s_d.pos = 3'd0; // [R15]
			end else begin
				s_d.sh = nsh;
				s_d.have = 1'b1;
				s_d.pos = s_q.pos + 3'd1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign byte_stb = s_q.byte_stb;
	assign byte_data = s_q.byte_data;
	assign fill_pos = s_q.pos;
	assign bit_count = s_q.cnt;
	assign coll_pos = s_q.cpos;
	assign coll_valid = s_q.cvalid;

endmodule
`default_nettype wire

// [rx_error_status.sv]
// Receive error flags, link state, bit framing control with APB access
//
// Functional notes
// [R1] Valid SOF followed by fewer than 4 data bits sets short-frame error.
// [R2] Frames under 4 bits dropped; decoder stays on; no receive-done pulse.
// [R3] With disturbance suppression, frames under 3 bytes dropped likewise.
// [R4] Four receive errors clear on receive start, or wait-for-data entry.
// [R5] Transmission due with empty FIFO sets the empty-send error.
// [R6] Collision sets collision flag and records first collision position.
// [R7] Collision inside the end-of-frame symbol does not set the flag.
// [R8] Wrong stop bit, SOF or byte count sets protocol error, stops reception.
// [R9] After a protocol error the last received byte never reaches the FIFO.
// [R10] Parity or CRC mismatch sets integrity error; reception continues.
// [R11] With control bit 3 set, a collision also sets integrity error.
// [R12] Status bit 5 shows cipher; software clears it, only authenticate sets.
// [R13] Link state codes: 000,001,011,101,110,111; 100 unused.
// [R14] With bit 7 clear, bits after a collision are stored as zero.
// [R15] Receive offset places first bit; later bits follow, wrapping bytes.
// [R16] Offset zero means byte-oriented, nonzero means bit-oriented reception.
// [R17] Last-byte-valid-bits gives valid bits of final byte; zero is whole.
// [R18] Decoder writes last-byte-valid-bits at bit-oriented end; reset at start.
// [R19] First collision position valid only within the first 8 bytes.
// [R20] Nonzero receive offset is added into the first collision position.
// [R21] Empty-send error holds until next command start or reset.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rx_error_status
	import rx_status_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmd_start,
	input wire logic [2:0] cmd_code,
	input wire logic tx_go,
	input wire logic tx_done,
	input wire logic fifo_empty,
	input wire logic rx_wait_done,
	input wire logic suppress_enable,
	input wire logic rx_sof,
	input wire logic rx_sof_err,
	input wire logic rx_bit_stb,
	input wire logic rx_bit,
	input wire logic rx_coll,
	input wire logic rx_coll_in_eof,
	input wire logic rx_stop_err,
	input wire logic rx_len_err,
	input wire logic rx_parity_err,
	input wire logic rx_crc_err,
	input wire logic rx_eof,
	input wire logic auth_ok,
	output logic [7:0] fifo_wdata,
	output logic fifo_wr,
	output logic receive_done_irq,
	output logic decoder_enable,
	output logic [2:0] link_state,
	output logic cipher_active,
	output logic [ERR_COUNT-1:0] error_flags
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		link_state_t state;
		cmd_t cmd;
		logic [QUEUE_DEPTH-1:0][7:0] q;
		logic [2:0] q_cnt;
		logic [2:0] commit;
		logic eof_pend;
		logic keep;
		logic [2:0] offset;
		logic noco;
		logic [2:0] last_bits;
		logic cipher;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [7:0] fifo_wdata;
		logic fifo_wr;
		logic irq;
		logic dec_en;
	} top_t;

	top_t s_q;
	top_t s_d;

	logic [ERR_COUNT-1:0] err_set;
	logic [ERR_COUNT-1:0] err_clr;
	logic pk_clear;
	logic pk_finish;
	logic pk_byte_stb;
	logic [7:0] pk_byte;
	logic [2:0] pk_fill;
	logic [7:0] pk_cnt;
	logic [6:0] pk_cpos;
	logic pk_cvalid;
	logic coll_hit;

	function automatic logic at_index(input logic [11:0] a, input logic [9:0] idx);
		return (a[11:2] == idx) && (a[1:0] == 2'b00);
	endfunction

	// Collisions are only counted inside data, not in the end symbol
	assign coll_hit = rx_bit_stb && rx_coll && !rx_coll_in_eof && (s_q.state == LS_RECV); // [R7]

	// ---------------------------------------------------------------
	// Submodules
	// ---------------------------------------------------------------
	rx_bit_packer u_packer (
		.pclk(pclk),
		.presetn(presetn),
		.clear(pk_clear),
		.finish(pk_finish),
		.offset(s_q.offset),
		.keep(s_q.keep),
		.bit_stb(rx_bit_stb && (s_q.state == LS_RECV)),
		.bit_val(rx_bit),
		.coll_stb(coll_hit),
		.byte_stb(pk_byte_stb),
		.byte_data(pk_byte),
		.fill_pos(pk_fill),
		.bit_count(pk_cnt),
		.coll_pos(pk_cpos),
		.coll_valid(pk_cvalid)
	);

	error_flag_bank #(
		.N(ERR_COUNT)
	) u_flags (
		.pclk(pclk),
		.presetn(presetn),
		.set(err_set),
		.clr(err_clr),
		.flags(error_flags)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		logic rd_phase;
		logic wr_take;
		logic prot;
		rd_phase = psel && penable && !s_q.pready;
		wr_take = psel && penable && s_q.pready && pwrite;
		prot = (s_q.state == LS_RECV) && (rx_stop_err || rx_len_err);
		s_d = s_q;
		s_d.fifo_wr = 1'b0;
		s_d.irq = 1'b0;
		err_set = '0;
		err_clr = '0;
		pk_clear = 1'b0;
		pk_finish = 1'b0;

		// FIFO drain: only committed bytes leave the holding queue
		if (s_q.commit != 3'd0) begin
			s_d.fifo_wr = 1'b1;
			s_d.fifo_wdata = s_q.q[0];
			for (int i = 0; i < QUEUE_DEPTH - 1; i++) begin
				s_d.q[i] = s_q.q[i+1];
			end
			s_d.q[QUEUE_DEPTH-1] = '0;
			s_d.q_cnt = s_q.q_cnt - 3'd1;
			s_d.commit = s_q.commit - 3'd1;
		end

		// A byte is held until a later bit proves it was not the last
		if (pk_byte_stb && (s_q.state == LS_RECV) && !prot && (s_d.q_cnt != 3'(QUEUE_DEPTH))) begin
			s_d.q[s_d.q_cnt[1:0]] = pk_byte;
			s_d.q_cnt = s_d.q_cnt + 3'd1;
		end
		if (rx_bit_stb && (s_q.state == LS_RECV) && !prot) begin
			if (!suppress_enable || (pk_cnt >= SUPPRESS_MIN_BITS)) begin // [R3]
				s_d.commit = s_d.q_cnt; // [R9]
			end
		end

		// Register writes before hardware updates so hardware wins
		if (wr_take && at_index(paddr, IDX_BITCTRL)) begin
			s_d.keep = pwdata[RBC_KEEP];
			s_d.offset = pwdata[RBC_OFFSET_LSB +: 3];
			s_d.noco = pwdata[RBC_COLLISION_AS_INTEGRITY_ERROR];
			s_d.last_bits = pwdata[RBC_LAST_LSB +: 3];
		end
		if (wr_take && at_index(paddr, IDX_STATUS) && !pwdata[ST_CIPHER]) begin
			s_d.cipher = 1'b0; // [R12]
		end
		if (auth_ok && (s_q.cmd == CMD_AUTH)) begin
			s_d.cipher = 1'b1; // [R12]
		end

		// -----------------------------------------------------------
		// Link sequencer
		// -----------------------------------------------------------
		if (cmd_start) begin
			err_clr[ERR_EMPTY] = 1'b1; // [R21]
			s_d.cmd = cmd_t'(cmd_code);
			s_d.eof_pend = 1'b0;
			case (cmd_code)
				CMD_RECEIVE: begin
					err_clr[ERR_SHORT] = 1'b1; // [R4]
					err_clr[ERR_COLL] = 1'b1;
					err_clr[ERR_PROT] = 1'b1;
					err_clr[ERR_INTEG] = 1'b1;
					s_d.state = LS_RX_WAIT; // [R13]
				end
				CMD_TRANSMIT, CMD_TRANSCEIVE, CMD_AUTH: begin
					s_d.state = LS_TX_WAIT; // [R13]
				end
				default: begin
					s_d.state = LS_IDLE;
				end
			endcase
		end else begin
			case (s_q.state)
				LS_TX_WAIT: begin
					if (tx_go) begin
						if (fifo_empty) begin
							err_set[ERR_EMPTY] = 1'b1; // [R5]
							s_d.state = LS_IDLE;
						end else begin
							s_d.state = LS_TXING; // [R13]
						end
					end
				end
				LS_TXING: begin
					if (tx_done) begin
						s_d.state = (s_q.cmd == CMD_TRANSMIT) ? LS_IDLE : LS_RX_WAIT; // [R13]
					end
				end
				LS_RX_WAIT: begin
					if (rx_wait_done) begin
						if (s_q.cmd != CMD_RECEIVE) begin
							err_clr[ERR_SHORT] = 1'b1; // [R4]
							err_clr[ERR_COLL] = 1'b1;
							err_clr[ERR_PROT] = 1'b1;
							err_clr[ERR_INTEG] = 1'b1;
						end
						s_d.state = LS_WAIT_DATA; // [R13]
					end
				end
				LS_WAIT_DATA: begin
					if (rx_sof_err) begin
						err_set[ERR_PROT] = 1'b1; // [R8]
						s_d.state = LS_IDLE;
					end else if (rx_sof) begin
						pk_clear = 1'b1;
						s_d.last_bits = 3'd0; // [R18]
						s_d.state = LS_RECV; // [R13]
					end
				end
				LS_RECV: begin
					if (prot) begin
						err_set[ERR_PROT] = 1'b1; // [R8]
						pk_clear = 1'b1;
						s_d.q_cnt = s_d.commit; // [R9]
						s_d.eof_pend = 1'b0;
						s_d.state = LS_IDLE; // [R8]
					end else begin
						if (rx_parity_err || rx_crc_err) begin
							err_set[ERR_INTEG] = 1'b1; // [R10]
						end
						if (coll_hit) begin
							err_set[ERR_COLL] = 1'b1; // [R6]
							if (s_q.noco) begin
								err_set[ERR_INTEG] = 1'b1; // [R11]
							end
						end
						if (s_q.eof_pend) begin
							s_d.eof_pend = 1'b0;
							if (pk_cnt < MIN_FRAME_BITS) begin
								err_set[ERR_SHORT] = 1'b1; // [R1]
								s_d.q_cnt = s_d.commit; // [R2]
								s_d.state = LS_WAIT_DATA; // [R2]
							end else if (suppress_enable && (pk_cnt < SUPPRESS_MIN_BITS)) begin
								s_d.q_cnt = s_d.commit; // [R3]
								s_d.state = LS_WAIT_DATA; // [R3]
							end else begin
								s_d.commit = s_d.q_cnt;
								if (s_q.offset != 3'd0) begin // [R16]
									s_d.last_bits = pk_fill; // [R17] [R18]
								end
								s_d.irq = 1'b1;
								s_d.state = LS_IDLE;
							end
						end else if (rx_eof) begin
							pk_finish = 1'b1;
							s_d.eof_pend = 1'b1;
						end
					end
				end
				default: begin
					s_d.state = LS_IDLE;
				end
			endcase
		end
		s_d.dec_en = (s_d.state == LS_WAIT_DATA) || (s_d.state == LS_RECV); // [R2]

		// -----------------------------------------------------------
		// APB: answer in the second access cycle
		// -----------------------------------------------------------
		if (rd_phase) begin
			s_d.pready = 1'b1;
			s_d.pslverr = 1'b0;
			s_d.prdata = '0;
			if (at_index(paddr, IDX_ERROR)) begin
				s_d.prdata[ERR_COUNT-1:0] = error_flags;
			end else if (at_index(paddr, IDX_STATUS)) begin
				s_d.prdata[ST_CIPHER] = s_q.cipher; // [R12]
				s_d.prdata[2:0] = s_q.state; // [R13]
			end else if (at_index(paddr, IDX_BITCTRL)) begin
				s_d.prdata[7:0] = {s_q.keep, s_q.offset, s_q.noco, s_q.last_bits};
			end else if (at_index(paddr, IDX_FIRST_COLLISION_POSITION)) begin
				s_d.prdata[COLL_VALID] = pk_cvalid; // [R19]
				s_d.prdata[6:0] = pk_cpos; // [R6]
			end else begin
				s_d.pslverr = 1'b1;
			end
		end else begin
			s_d.pready = 1'b0;
			s_d.pslverr = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.state <= LS_IDLE;
			s_q.cmd <= CMD_IDLE;
			{s_q.keep, s_q.offset, s_q.noco, s_q.last_bits} <= BITCTRL_RESET;
			s_q.cipher <= CIPHER_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign fifo_wdata = s_q.fifo_wdata;
	assign fifo_wr = s_q.fifo_wr;
	assign receive_done_irq = s_q.irq;
	assign decoder_enable = s_q.dec_en;
	assign link_state = s_q.state;
	assign cipher_active = s_q.cipher;

endmodule
`default_nettype wire

// [rx_error_status_properties.sv]
// Concurrent checks on the receive status block ports
`timescale 1ns/1ps
`default_nettype none
module rx_error_status_checker
	import rx_status_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cmd_start,
	input wire logic [2:0] cmd_code,
	input wire logic tx_go,
	input wire logic fifo_empty,
	input wire logic rx_wait_done,
	input wire logic rx_bit_stb,
	input wire logic rx_coll,
	input wire logic rx_coll_in_eof,
	input wire logic rx_stop_err,
	input wire logic rx_len_err,
	input wire logic rx_parity_err,
	input wire logic rx_eof,
	input wire logic auth_ok,
	input wire logic receive_done_irq,
	input wire logic decoder_enable,
	input wire logic [2:0] link_state,
	input wire logic cipher_active,
	input wire logic [ERR_COUNT-1:0] error_flags
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_recv_start;
		cmd_start && cmd_code == CMD_RECEIVE;
	endsequence
	sequence s_rx_cleared;
		(error_flags & 5'h17) == 5'h00;
	endsequence
	sequence s_in_rx;
		link_state == LS_RECV && !cmd_start;
	endsequence
	property p_recv_clear;
		s_recv_start |=> link_state == LS_RX_WAIT ##0 s_rx_cleared;
	endproperty
	property p_wait_data;
		link_state == LS_RX_WAIT && rx_wait_done && !cmd_start |=> link_state == LS_WAIT_DATA ##0 s_rx_cleared;
	endproperty
	property p_empty;
		link_state == LS_TX_WAIT && tx_go && fifo_empty && !cmd_start |=> error_flags[ERR_EMPTY] && link_state == LS_IDLE;
	endproperty
	property p_prot;
		s_in_rx ##0 (rx_stop_err || rx_len_err) |=> error_flags[ERR_PROT] && link_state == LS_IDLE;
	endproperty
	property p_integ;
		s_in_rx ##0 rx_parity_err && !rx_eof && !rx_stop_err && !rx_len_err
			|=> error_flags[ERR_INTEG] && link_state == LS_RECV;
	endproperty
	property p_coll_eof;
		s_in_rx ##0 rx_bit_stb && rx_coll && rx_coll_in_eof && !error_flags[ERR_COLL] |=> !error_flags[ERR_COLL];
	endproperty
	property p_decoder;
		decoder_enable == (link_state == LS_WAIT_DATA || link_state == LS_RECV);
	endproperty
	property p_short_quiet;
		$rose(error_flags[ERR_SHORT]) |-> !receive_done_irq [*4];
	endproperty
	property p_cipher_set;
		$rose(cipher_active) |-> $past(auth_ok);
	endproperty
	property p_state_code;
		link_state inside {LS_IDLE, LS_TX_WAIT, LS_TXING, LS_RX_WAIT, LS_WAIT_DATA, LS_RECV};
	endproperty
	a_recv_clear: assert property (p_recv_clear) else $error("flags not cleared on receive start");
	a_wait_data: assert property (p_wait_data) else $error("bad wait-for-data entry");
	a_empty: assert property (p_empty) else $error("empty send not flagged");
	a_prot: assert property (p_prot) else $error("protocol error not handled");
	a_integ: assert property (p_integ) else $error("integrity error not handled");
	a_coll_eof: assert property (p_coll_eof) else $error("end-of-frame collision flagged");
	a_decoder: assert property (p_decoder) else $error("decoder enable wrong");
	a_short_quiet: assert property (p_short_quiet) else $error("receive done on short frame");
	a_cipher_set: assert property (p_cipher_set) else $error("cipher set without authentication");
	a_state_code: assert property (p_state_code) else $error("illegal link state code");
endmodule
bind rx_error_status rx_error_status_checker chk_u (.pclk, .presetn, .cmd_start, .cmd_code, .tx_go, .fifo_empty,
	.rx_wait_done, .rx_bit_stb, .rx_coll, .rx_coll_in_eof, .rx_stop_err, .rx_len_err, .rx_parity_err, .rx_eof,
	.auth_ok, .receive_done_irq, .decoder_enable, .link_state, .cipher_active, .error_flags);
`default_nettype wire

// [card_model.sv]
// Card side of the RF link: frame start, data bits, collisions, frame end
`timescale 1ns/1ps
`default_nettype none
module card_model (
	input wire logic pclk,
	output logic rx_sof,
	output logic rx_bit_stb,
	output logic rx_bit,
	output logic rx_coll,
	output logic rx_coll_in_eof,
	output logic rx_parity_err,
	output logic rx_stop_err,
	output logic rx_eof
);
	initial begin
		{rx_sof, rx_bit_stb, rx_bit, rx_coll, rx_coll_in_eof, rx_parity_err, rx_stop_err, rx_eof} = 8'h00;
	end
	// Kind 0 clean end, 1 collision inside end symbol, 2 parity slip then bad stop bit
	task automatic frame(input int n, input logic [15:0] b, input int ci, input int kind);
		rx_sof <= 1'b1;
		@(posedge pclk);
		rx_sof <= 1'b0;
		for (int i = 0; i < n; i++) begin
			rx_bit_stb <= 1'b1;
			rx_bit <= b[i];
			rx_coll <= (i == ci) || (kind == 1 && i == n - 1);
			rx_coll_in_eof <= kind == 1 && i == n - 1;
			rx_parity_err <= kind == 2 && i == 0;
			@(posedge pclk);
			rx_bit_stb <= 1'b0;
			rx_coll <= 1'b0;
			rx_coll_in_eof <= 1'b0;
			rx_parity_err <= 1'b0;
			// Line between bits carries no data; show the opposite level
			rx_bit <= ~b[i];
			@(posedge pclk);
		end
		if (kind == 2) begin
			rx_stop_err <= 1'b1;
		end else begin
			rx_eof <= 1'b1;
		end
		@(posedge pclk);
		rx_stop_err <= 1'b0;
		rx_eof <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [contactless_rx_error_status_tb_top.sv]
// Self-checking bench for the receive status block
`timescale 1ns/1ps
`default_nettype none
module contactless_rx_error_status_tb_top
	import rx_status_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic cmd_start = 1'b0, tx_go = 1'b0, tx_done = 1'b0, fifo_empty = 1'b0, rx_wait_done = 1'b0, auth_ok = 1'b0;
	logic [2:0] cmd_code = 3'h0, link_state;
	logic suppress_enable = 1'b0, rx_sof_err = 1'b0, rx_len_err = 1'b0, rx_crc_err = 1'b0;
	logic rx_sof, rx_bit_stb, rx_bit, rx_coll, rx_coll_in_eof, rx_parity_err, rx_stop_err, rx_eof;
	logic [7:0] fifo_wdata, last_b, prev_b;
	logic fifo_wr, receive_done_irq, decoder_enable, cipher_active;
	logic [ERR_COUNT-1:0] error_flags;
	int num_errors = 0, comparisons = 0, irqs = 0, nbytes = 0, n0, i0;
	rx_error_status dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.cmd_start, .cmd_code, .tx_go, .tx_done, .fifo_empty, .rx_wait_done, .suppress_enable, .rx_sof, .rx_sof_err,
		.rx_bit_stb, .rx_bit, .rx_coll, .rx_coll_in_eof, .rx_stop_err, .rx_len_err, .rx_parity_err, .rx_crc_err,
		.rx_eof, .auth_ok, .fifo_wdata, .fifo_wr, .receive_done_irq, .decoder_enable, .link_state, .cipher_active,
		.error_flags);
	card_model card_u (.pclk, .rx_sof, .rx_bit_stb, .rx_bit, .rx_coll, .rx_coll_in_eof, .rx_parity_err,
		.rx_stop_err, .rx_eof);
	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		if (receive_done_irq === 1'b1) irqs++;
		if (fifo_wr === 1'b1) begin
			nbytes++;
			prev_b <= last_b;
			last_b <= fifo_wdata;
		end
	end
	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task end_sim;
		$display("checks %0d, errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task apb(input logic w, input logic [9:0] idx, input logic [7:0] d, output logic [7:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task cmd(input logic [2:0] c);
		cmd_start <= 1'b1;
		cmd_code <= c;
		@(posedge pclk);
		cmd_start <= 1'b0;
		@(posedge pclk);
	endtask
	task to_wait_data;
		cmd(CMD_RECEIVE);
		rx_wait_done <= 1'b1;
		@(posedge pclk);
		rx_wait_done <= 1'b0;
		@(posedge pclk);
	endtask
	task tx_phase(input logic empty);
		fifo_empty <= empty;
		tx_go <= 1'b1;
		@(posedge pclk);
		tx_go <= 1'b0;
		fifo_empty <= 1'b0;
		@(posedge pclk);
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task t_regs;
		logic [7:0] r;
		logic e;
		apb(1'b1, IDX_ERROR, 8'hff, r, e);
		apb(1'b0, IDX_ERROR, 8'h00, r, e);
		chk("error reg", r, ERROR_RESET);
		apb(1'b0, IDX_STATUS, 8'h00, r, e);
		chk("status reg", r, 8'h00);
		apb(1'b0, IDX_BITCTRL, 8'h00, r, e);
		chk("bit control", r, BITCTRL_RESET);
		apb(1'b0, 10'h00f, 8'h00, r, e);
		chk("unmapped slverr", {7'h00, e}, 8'h01);
	endtask
	task t_short;
		to_wait_data();
		chk("state", {5'h00, link_state}, {5'h00, LS_WAIT_DATA});
		i0 = irqs;
		n0 = nbytes;
		card_u.frame(3, 16'h0007, 99, 0);
		idle(6);
		chk("short flag", {7'h00, error_flags[ERR_SHORT]}, 8'h01);
		chk("decoder", {7'h00, decoder_enable}, 8'h01);
		chk("short irq", 8'(irqs - i0), 8'h00);
		chk("short bytes", 8'(nbytes - n0), 8'h00);
		suppress_enable <= 1'b1;
		card_u.frame(8, 16'h00a5, 99, 0);
		idle(6);
		chk("supp irq", 8'(irqs - i0), 8'h00);
		chk("supp bytes", 8'(nbytes - n0), 8'h00);
		chk("supp state", {5'h00, link_state}, {5'h00, LS_WAIT_DATA});
		suppress_enable <= 1'b0;
		card_u.frame(8, 16'h00a5, 99, 1);
		idle(8);
		chk("frame irq", 8'(irqs - i0), 8'h01);
		chk("frame byte", last_b, 8'ha5);
		chk("eof collision", {7'h00, error_flags[ERR_COLL]}, 8'h00);
		chk("flag held", {7'h00, error_flags[ERR_SHORT]}, 8'h01);
		to_wait_data();
		chk("flags cleared", {3'h0, error_flags}, 8'h00);
	endtask
	task t_tx;
		cmd(CMD_TRANSMIT);
		chk("tx wait", {5'h00, link_state}, {5'h00, LS_TX_WAIT});
		tx_phase(1'b0);
		chk("txing", {5'h00, link_state}, {5'h00, LS_TXING});
		cmd(CMD_TRANSMIT);
		tx_phase(1'b1);
		chk("empty flag", {7'h00, error_flags[ERR_EMPTY]}, 8'h01);
		idle(5);
		chk("empty held", {7'h00, error_flags[ERR_EMPTY]}, 8'h01);
		cmd(CMD_IDLE);
		chk("empty cleared", {7'h00, error_flags[ERR_EMPTY]}, 8'h00);
	endtask
	task t_coll;
		logic [7:0] r;
		logic e;
		apb(1'b1, IDX_BITCTRL, 8'h48, r, e);
		to_wait_data();
		n0 = nbytes;
		card_u.frame(6, 16'h003f, 1, 0);
		idle(8);
		chk("coll bytes", 8'(nbytes - n0), 8'h02);
		chk("first byte", prev_b, 8'h30);
		chk("last byte", last_b, 8'h00);
		chk("coll flags", {3'h0, error_flags}, 8'h05);
		apb(1'b0, IDX_BITCTRL, 8'h00, r, e);
		chk("last bits", r, 8'h4a);
		apb(1'b0, IDX_FIRST_COLLISION_POSITION, 8'h00, r, e);
		chk("coll position", r, 8'h85);
		cmd(CMD_TRANSCEIVE);
		chk("kept at start", {3'h0, error_flags}, 8'h05);
		tx_phase(1'b0);
		tx_done <= 1'b1;
		@(posedge pclk);
		tx_done <= 1'b0;
		@(posedge pclk);
		chk("rx wait", {5'h00, link_state}, {5'h00, LS_RX_WAIT});
		rx_wait_done <= 1'b1;
		@(posedge pclk);
		rx_wait_done <= 1'b0;
		@(posedge pclk);
		chk("cleared at wait", {3'h0, error_flags}, 8'h00);
		apb(1'b1, IDX_BITCTRL, 8'h00, r, e);
	endtask
	task t_prot;
		to_wait_data();
		n0 = nbytes;
		i0 = irqs;
		card_u.frame(16, 16'h5a3c, 99, 2);
		idle(6);
		chk("prot flags", {3'h0, error_flags}, 8'h03);
		chk("prot state", {5'h00, link_state}, {5'h00, LS_IDLE});
		chk("prot bytes", 8'(nbytes - n0), 8'h01);
		chk("prot byte", last_b, 8'h3c);
		chk("prot irq", 8'(irqs - i0), 8'h00);
		to_wait_data();
		rx_sof_err <= 1'b1;
		@(posedge pclk);
		rx_sof_err <= 1'b0;
		@(posedge pclk);
		chk("sof error", {3'h0, error_flags}, 8'h02);
	endtask
	task t_cipher;
		logic [7:0] r;
		logic e;
		auth_ok <= 1'b1;
		@(posedge pclk);
		auth_ok <= 1'b0;
		idle(2);
		chk("no auth", {7'h00, cipher_active}, 8'h00);
		cmd(CMD_AUTH);
		auth_ok <= 1'b1;
		@(posedge pclk);
		auth_ok <= 1'b0;
		@(posedge pclk);
		apb(1'b0, IDX_STATUS, 8'h00, r, e);
		chk("cipher on", r, 8'h21);
		apb(1'b1, IDX_STATUS, 8'h20, r, e);
		chk("cipher kept", {7'h00, cipher_active}, 8'h01);
		apb(1'b1, IDX_STATUS, 8'h00, r, e);
		chk("cipher off", {7'h00, cipher_active}, 8'h00);
		cmd(CMD_IDLE);
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_short();
		t_tx();
		t_coll();
		t_prot();
		t_cipher();
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		end_sim();
	end
endmodule
`default_nettype wire
